// ---- hw/rftx_pkg.sv ----
// constants for the transmitter two-wire configuration port
// assumes a 40 MHz system clock and a host driving the config pins
package rftx_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [4:0] FRAME_EDGES = 5'h18;
  localparam logic [4:0] PREFIX_EDGES = 5'h08;
  localparam logic [7:0] CMD_APP_WR = 8'h00;
  localparam logic [7:0] CMD_APP_RD = 8'h33;
  localparam logic [4:0] CMD_CAR_WR = 5'h03;
  localparam logic [7:0] CMD_CAR_RD = 8'h44;
  localparam logic [7:0] CMD_STAT_RD = 8'h55;
  // application word bit positions
  localparam int MODE_POS = 15;
  localparam int MODUL_POS = 14;
  localparam int BAND_POS = 13;
  localparam int DEV_MSB = 12;
  localparam int DEV_LSB = 5;
  localparam int POWER_POS = 4;
  localparam int OFFT_POS = 3;
  // power-on sets, chosen by the config clock level
  localparam logic [15:0] APP_RST_LO = 16'h401C;
  localparam logic [15:0] APP_RST_HI = 16'h20D4;
  localparam logic [18:0] CAR_RST_LO = 19'h42C1C;
  localparam logic [18:0] CAR_RST_HI = 19'h42CAD;
  localparam int STATE_TX_POS = 1;
  // cycles for the pin filters to settle before the strap is taken
  localparam logic [2:0] STRAP_WAIT = 3'h4;
  localparam int T_WAKE_NS = 5000;
  localparam int WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_OFFT_SHORT_MS = 2;
  localparam int T_OFFT_LONG_MS = 20;
  localparam int OFFT_SHORT_CYC = T_OFFT_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OFFT_LONG_CYC = T_OFFT_LONG_MS * 1000000 / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_STRAP = 2'h0,
    ST_SLEEP = 2'h1,
    ST_TX = 2'h3
  } rftx_state_t;
endpackage

// ---- hw/rftx_pin_filter.sv ----
// three-flop pin synchroniser with agreement filter, two pins
// assumes the inputs are asynchronous to sys_clk_i
`timescale 1ns/1ps
module rftx_pin_filter (
  input wire logic sys_clk_i,       // system clock
  input wire logic rst_b_i,         // sync reset, active low
  input wire logic [1:0] pin_i,     // raw pins
  output logic [1:0] level_o        // filtered levels
);
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, lvl_reg;
      logic lvl_next;
      always_comb begin
        lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end else begin
          s1_reg <= pin_i[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          lvl_reg <= lvl_next;
        end
      end
      assign level_o[gi] = lvl_reg;
    end
  endgenerate
endmodule

// ---- hw/rftx_cfg_port.sv ----
// transmitter config port: 24-edge frames, strap presets, sleep/transmit
// assumes the host drives cfg_clk_i and shares the data pin
`timescale 1ns/1ps
// Overview of operation
// - data pin is sampled on each rising config clock edge in a frame.
// - a frame is exactly 24 rising edges; shorter frames complete nothing.
// - config clock level at power-on picks one of two preset sets.
// - after power-on the transmitter sleeps while data is held low.
// - a recovery pattern on the pins resynchronises the frame logic.
// - three registers: application, 19-bit carrier, read-only status.
// - prefixes select application or carrier write and application, carrier or status read.
// - mode bit, 0 automatic, 1 manual continuous; presets to 0.
// - modulation bit, 0 FSK, 1 OOK; presets 1 low, 0 high.
// - band bit, 0 low band, 1 high bands; presets 0 low, 1 high.
// - 8-bit deviation used in FSK only; presets 0x06 when high.
// - power bit presets 1; off-time bit 2/20 ms, presets 1 or 0.
// - once configured, the data pin is the modulation input.
module rftx_cfg_port #(
  parameter int OFFT_SHORT_CYC = rftx_pkg::OFFT_SHORT_CYC,
  parameter int OFFT_LONG_CYC = rftx_pkg::OFFT_LONG_CYC,
  parameter logic [7:0] VERSION = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_RST_LO = 8'h00
) (
  input wire logic sys_clk_i,               // system clock, 40 MHz
  input wire logic rst_b_i,                 // power-on reset, active low
  input wire logic cfg_clk_i,               // config clock pin
  input wire logic data_i,                  // data pin, input side
  output logic data_o,                      // data pin, output side
  output logic data_oe_o,                   // data pin drive enable
  output logic mode_select_bit_o,           // 1 manual transmit
  output logic modulation_select_bit_o,     // 1 OOK, 0 FSK
  output logic band_select_bit_o,           // 1 high bands
  output logic [7:0] deviation_field_o,     // FSK deviation
  output logic power_level_bit_o,           // 1 high power
  output logic off_time_bit_o,              // 1 long sleep timeout
  output logic [18:0] carrier_word_o,       // carrier frequency word
  output logic tx_active_o,                 // transmitting
  output logic mod_data_o                   // modulation data
);
  logic [1:0] lvl;
  logic clk_f, dat_f, rise, dchg, rec, last_edge;
  // 20 bits: the long timeout count at 40 MHz does not fit in 19
  logic [19:0] off_lim;
  logic [15:0] rd_word;
  logic [23:0] sh_in;
  rftx_pkg::rftx_state_t state_reg, state_next;
  logic clk_q_reg, clk_q_next, dat_q_reg, dat_q_next;
  logic [2:0] strap_reg, strap_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] sh_reg, sh_next;
  logic [15:0] rd_reg, rd_next, app_reg, app_next;
  logic [18:0] car_reg, car_next;
  logic [19:0] off_reg, off_next;
  logic [7:0] wake_reg, wake_next;
  logic [1:0] tog_reg, tog_next;
  logic oe_reg, oe_next, dout_reg, dout_next;
  logic tx_reg, tx_next, mod_reg, mod_next;

  rftx_pin_filter u_filt (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({data_i, cfg_clk_i}),
    .level_o(lvl)
  );

  always_comb begin
    clk_f = lvl[0];
    dat_f = lvl[1];
    rise = clk_f & ~clk_q_reg & (state_reg != rftx_pkg::ST_STRAP);
    dchg = dat_f ^ dat_q_reg;
    // two data changes within one config clock high phase
    rec = clk_f & ~rise & dchg & ~oe_reg & (tog_reg == 2'h1);
    last_edge = rise & (cnt_reg == rftx_pkg::FRAME_EDGES - 5'h01);
    sh_in = {sh_reg[22:0], dat_f};
    off_lim = off_time_bit_o ? 20'(OFFT_LONG_CYC) : 20'(OFFT_SHORT_CYC);
    unique case (sh_in[7:0])
      rftx_pkg::CMD_APP_RD: rd_word = app_reg;
      rftx_pkg::CMD_CAR_RD: rd_word = car_reg[15:0];
      default: rd_word = {VERSION, 3'h0, tx_reg, 1'b0, car_reg[18:16]};
    endcase
    clk_q_next = clk_f;
    dat_q_next = dat_f;
    state_next = state_reg;
    strap_next = strap_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    rd_next = rd_reg;
    app_next = app_reg;
    car_next = car_reg;
    oe_next = oe_reg;
    dout_next = dout_reg;
    tog_next = tog_reg;
    wake_next = wake_reg;
    off_next = off_reg;
    if (rise) begin
      sh_next = sh_in;
      cnt_next = cnt_reg + 5'h01;
      tog_next = 2'h0;
      if (cnt_reg == rftx_pkg::PREFIX_EDGES - 5'h01 &&
          (sh_in[7:0] == rftx_pkg::CMD_APP_RD ||
           sh_in[7:0] == rftx_pkg::CMD_CAR_RD ||
           sh_in[7:0] == rftx_pkg::CMD_STAT_RD)) begin
        oe_next = 1'b1;
        dout_next = rd_word[15];
        rd_next = {rd_word[14:0], 1'b0};
      end else if (oe_reg) begin
        dout_next = rd_reg[15];
        rd_next = {rd_reg[14:0], 1'b0};
      end
      if (last_edge) begin
        cnt_next = 5'h00;
        oe_next = 1'b0;
        dout_next = 1'b0;
        if (sh_in[23:16] == rftx_pkg::CMD_APP_WR) begin
          app_next = sh_in[15:0];
        end else if (sh_in[23:19] == rftx_pkg::CMD_CAR_WR) begin
          car_next = sh_in[18:0];
        end
      end
    end else if (clk_f && dchg && !oe_reg) begin
      tog_next = tog_reg + 2'h1;
    end
    if (rec) begin
      cnt_next = 5'h00;
      tog_next = 2'h0;
    end
    wake_next = (dat_f && !rise && cnt_reg == 5'h00 &&
                 wake_reg != 8'(rftx_pkg::WAKE_CYC)) ? wake_reg + 8'h01 :
                (dat_f && !rise && cnt_reg == 5'h00) ? wake_reg : 8'h00;
    off_next = (dat_f || state_reg != rftx_pkg::ST_TX) ? 20'h00000 :
               (off_reg == off_lim) ? off_reg : off_reg + 20'h00001;
    unique case (state_reg)
      rftx_pkg::ST_STRAP: begin
        strap_next = strap_reg + 3'h1;
        if (strap_reg == rftx_pkg::STRAP_WAIT) begin
          app_next = clk_f ? rftx_pkg::APP_RST_HI :
                     {rftx_pkg::APP_RST_LO[15:13], DEV_RST_LO,
                      rftx_pkg::APP_RST_LO[4:0]};
          car_next = clk_f ? rftx_pkg::CAR_RST_HI : rftx_pkg::CAR_RST_LO;
          state_next = rftx_pkg::ST_SLEEP;
        end
      end
      rftx_pkg::ST_SLEEP: begin
        if ((app_reg[rftx_pkg::MODE_POS] && cnt_reg == 5'h00) ||
            wake_reg == 8'(rftx_pkg::WAKE_CYC)) begin
          state_next = rftx_pkg::ST_TX;
        end
      end
      rftx_pkg::ST_TX: begin
        if (!app_reg[rftx_pkg::MODE_POS] && off_reg == off_lim) begin
          state_next = rftx_pkg::ST_SLEEP;
        end
      end
      default: state_next = rftx_pkg::ST_STRAP;
    endcase
    tx_next = (state_next == rftx_pkg::ST_TX);
    mod_next = tx_next & dat_f;
    if (rec) begin
      oe_next = 1'b0;
      dout_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= rftx_pkg::ST_STRAP;
      clk_q_reg <= 1'b0;
      dat_q_reg <= 1'b0;
      strap_reg <= 3'h0;
      cnt_reg <= 5'h00;
      sh_reg <= 24'h000000;
      rd_reg <= 16'h0000;
      app_reg <= rftx_pkg::APP_RST_LO;
      car_reg <= rftx_pkg::CAR_RST_LO;
      oe_reg <= 1'b0;
      dout_reg <= 1'b0;
      tog_reg <= 2'h0;
      wake_reg <= 8'h00;
      off_reg <= 20'h00000;
      tx_reg <= 1'b0;
      mod_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      clk_q_reg <= clk_q_next;
      dat_q_reg <= dat_q_next;
      strap_reg <= strap_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      rd_reg <= rd_next;
      app_reg <= app_next;
      car_reg <= car_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
      tog_reg <= tog_next;
      wake_reg <= wake_next;
      off_reg <= off_next;
      tx_reg <= tx_next;
      mod_reg <= mod_next;
    end
  end

  assign data_o = dout_reg;
  assign data_oe_o = oe_reg;
  assign mode_select_bit_o = app_reg[rftx_pkg::MODE_POS];
  assign modulation_select_bit_o = app_reg[rftx_pkg::MODUL_POS];
  assign band_select_bit_o = app_reg[rftx_pkg::BAND_POS];
  assign deviation_field_o = app_reg[rftx_pkg::DEV_MSB:rftx_pkg::DEV_LSB];
  assign power_level_bit_o = app_reg[rftx_pkg::POWER_POS];
  assign off_time_bit_o = app_reg[rftx_pkg::OFFT_POS];
  assign carrier_word_o = car_reg;
  assign tx_active_o = tx_reg;
  assign mod_data_o = mod_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_edge_count: assert property (
    rise && !last_edge && !rec |=> cnt_reg == $past(cnt_reg) + 5'h01)
    else $error("edge counter did not advance");
  a_frame_wrap: assert property (
    last_edge |=> cnt_reg == 5'h00 && !oe_reg)
    else $error("frame did not end at edge 24");
  a_short_nowrite: assert property (
    rise && !last_edge |=>
    app_reg == $past(app_reg) && car_reg == $past(car_reg))
    else $error("register changed before edge 24");
  a_strap_low: assert property (
    state_reg == rftx_pkg::ST_STRAP &&
    strap_reg == rftx_pkg::STRAP_WAIT && !clk_f |=>
    app_reg[15:13] == 3'h2 && app_reg[4:0] == 5'h1C &&
    car_reg == 19'h42C1C)
    else $error("low preset not loaded");
  a_strap_high: assert property (
    state_reg == rftx_pkg::ST_STRAP &&
    strap_reg == rftx_pkg::STRAP_WAIT && clk_f |=>
    app_reg == 16'h20D4 && car_reg == 19'h42CAD)
    else $error("high preset not loaded");
  a_mode_reset: assert property (
    $past(state_reg) == rftx_pkg::ST_STRAP &&
    state_reg == rftx_pkg::ST_SLEEP |-> !app_reg[15])
    else $error("mode bit not cleared at power-on");
  a_recover_clear: assert property (
    rec |=> cnt_reg == 5'h00 && !data_oe_o)
    else $error("recovery left a partial frame");
  a_app_write: assert property (
    last_edge && sh_in[23:16] == 8'h00 |=> app_reg == $past(sh_in[15:0]))
    else $error("application write lost");
  // drive starts with the counter at 8, after the eighth edge
  a_read_drive: assert property (
    data_oe_o |-> cnt_reg >= 5'h08)
    else $error("data driven outside payload");
  a_mod_idle: assert property (!tx_active_o |-> !mod_data_o)
    else $error("modulation out of transmit state");
  a_sleep_hold: assert property (state_reg == rftx_pkg::ST_SLEEP &&
    !dat_f && !app_reg[15] |=> !tx_active_o)
    else $error("woke with data low");

  c_read: cover property (rise && cnt_reg == 5'h07 && rd_word != 16'h0000
    ##1 data_oe_o);
  c_write: cover property (last_edge && sh_in[23:19] == 5'h03);
  c_recover: cover property (rec && cnt_reg != 5'h00);
  c_tx: cover property (!tx_active_o ##1 tx_active_o);
endmodule

// ---- bench/rftx_host_model.sv ----
// host side of the config link: clock pin, data pin, resolved wire
// assumes the device drives data only while its enable is high
`timescale 1ns/1ps
module rftx_host_model (
  input wire logic dev_d_i,  // device data drive
  input wire logic dev_oe_i, // device drive enable
  output logic cfg_clk_o,    // config clock pin
  output logic wire_o        // resolved data wire
);
  logic host_d;
  logic host_en;
  // a released wire shows the inverse of the host data bit host_d
  assign wire_o = dev_oe_i ? dev_d_i : (host_en ? host_d : ~host_d);
  initial begin
    cfg_clk_o = 1'b0;
    host_d = 1'b0;
    host_en = 1'b1;
  end
  // n edges, msb first, data moved only while clock low
  task automatic frame(input logic [23:0] w, input bit rd, input int n,
                       output logic [15:0] q);
    q = 16'h0000;
    // pins move by non-blocking assignment, on system clock edges
    for (int k = 23; k >= 24 - n; k--) begin
      cfg_clk_o <= 1'b0;
      host_d <= w[k]; // frame word bit k, msb first
      host_en <= !(rd && k < 16);
      #100;
      if (rd && k < 16) begin
        q[k] = wire_o;
      end
      cfg_clk_o <= 1'b1;
      #100;
    end
    cfg_clk_o <= 1'b0;
    host_d <= 1'b0; // back to sleep level between frames
    host_en <= 1'b1;
    #400;
  endtask
  // two data changes in one clock-high phase
  task automatic recover();
    cfg_clk_o <= 1'b1;
    #150;
    host_d <= 1'b1;
    #150;
    host_d <= 1'b0;
    #150;
    cfg_clk_o <= 1'b0;
    #400;
  endtask
endmodule

// ---- bench/rftx_cfg_port_tb.sv ----
// self-checking bench for the config port, host model on the pins
// assumes short off-time counts of 40 and 400 cycles
`timescale 1ns/1ps
module rftx_cfg_port_tb;
  logic sys_clk_i;
  logic rst_b_i;
  logic cfg_clk;
  logic dwire;
  logic d_o;
  logic d_oe;
  logic [12:0] app;
  logic [18:0] car;
  logic tx;
  logic mod_d;
  logic [15:0] q;
  int n_errors;
  int samples_checked;
  localparam logic [7:0] VER = 8'h5C; // arbitrary value
  rftx_cfg_port #(.OFFT_SHORT_CYC(40), .OFFT_LONG_CYC(400),
    .VERSION(VER)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_clk_i(cfg_clk),
    .data_i(dwire), .data_o(d_o), .data_oe_o(d_oe),
    .mode_select_bit_o(app[12]), .modulation_select_bit_o(app[11]),
    .band_select_bit_o(app[10]), .deviation_field_o(app[9:2]),
    .power_level_bit_o(app[1]), .off_time_bit_o(app[0]),
    .carrier_word_o(car), .tx_active_o(tx), .mod_data_o(mod_d));
  rftx_host_model host_u (.dev_d_i(d_o), .dev_oe_i(d_oe),
    .cfg_clk_o(cfg_clk), .wire_o(dwire));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string nm, input logic [23:0] s,
                     input logic [23:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_tx(input logic v, input int n);
    int i;
    i = 0;
    while (tx !== v && i < n) begin
      @(posedge sys_clk_i);
      i++;
    end
    if (tx !== v) begin
      chk("tx_wait", {23'h0, tx}, {23'h0, v});
      final_report();
    end
  endtask
  task automatic t_reset(input logic strap);
    host_u.cfg_clk_o <= strap; // held at strap level
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    if (strap) begin
      chk("app_hi", app, {3'b001, 8'h06, 2'b10});
      chk("mode_hi", app[12:11], 2'b00);
      chk("pwr_hi", app[1:0], 2'b10);
      chk("car_hi", car, 19'h42CAD);
    end else begin
      chk("app_lo", app, {3'b010, 8'h00, 2'b11});
      chk("mode_lo", app[12:11], 2'b01);
      chk("pwr_lo", app[1:0], 2'b11);
      chk("car_lo", car, 19'h42C1C);
    end
    chk("sleep", {d_oe, tx}, 2'b00);
  endtask
  task automatic t_app(input logic [15:0] v);
    host_u.frame({8'h00, v}, 0, 24, q);
    chk("app_wr", app, v[15:3]);
    host_u.frame({8'h33, 16'h0000}, 1, 24, q);
    chk("app_rd", q, v);
    chk("rd_release", d_oe, 1'b0);
  endtask
  task automatic t_car();
    host_u.frame({5'h03, 19'h5A3C7}, 0, 24, q);
    chk("car_wr", car, 19'h5A3C7);
    host_u.frame({8'h44, 16'h0000}, 1, 24, q);
    chk("car_rd", q, 16'hA3C7);
    host_u.frame({8'h55, 16'h0000}, 1, 24, q);
    chk("stat_rd", q, {VER, 8'h05});
  endtask
  task automatic t_rec();
    host_u.frame({8'h00, 16'h0000}, 0, 10, q);
    chk("short", app, 13'h0759);
    host_u.recover();
    host_u.frame({8'h00, 16'h2D2C}, 0, 24, q);
    chk("after_rec", app, 13'h05A5);
    host_u.frame(24'hFFFFFF, 0, 24, q);
    chk("bad_pfx", app, 13'h05A5);
  endtask
  task automatic t_tx();
    host_u.host_d <= 1'b1;
    wait_tx(1'b1, 400);
    chk("tx_on", {tx, mod_d}, 2'b11);
    host_u.host_d <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    chk("mod_low", {tx, mod_d}, 2'b10);
    repeat (300) @(posedge sys_clk_i);
    chk("long_off", tx, 1'b1);
    wait_tx(1'b0, 300);
    chk("tx_off", tx, 1'b0);
    // manual mode is only left by a write while transmitting
    host_u.frame({8'h00, 16'hAD2C}, 0, 24, q);
    wait_tx(1'b1, 20);
    chk("manual_on", {app[12], tx}, 2'b11);
    repeat (420) @(posedge sys_clk_i);
    chk("manual_hold", tx, 1'b1);
    host_u.frame({8'h00, 16'h2D2C}, 0, 24, q);
    wait_tx(1'b0, 500);
    chk("manual_off", {app[12], tx}, 2'b00);
  endtask
  initial begin
    n_errors = 0;
    samples_checked = 0;
    rst_b_i = 1'b0;
    t_reset(1'b0);
    t_app(16'h3ACC);
    t_car();
    t_rec();
    t_tx();
    t_reset(1'b1);
    final_report();
  end
endmodule
